// ---- core/csm_cfg.svh ----
// constants of the clock-select and module-stop block
// assumes a 16-bit register set reached through a word-addressed bus
`ifndef CSM_CFG_SVH
`define CSM_CFG_SVH
// register indices; byte address is four times the index
`define CSM_IDX_CLK_SEL 24'hFFFDC4
`define CSM_IDX_STOP_A 24'hFFFDC8
`define CSM_IDX_STOP_B 24'hFFFDCA
`define CSM_IDX_STOP_C 24'hFFFDCC
// selector field positions in the clock-select register
`define CSM_SYS_SEL_LSB 8
`define CSM_PER_SEL_LSB 4
`define CSM_BUS_SEL_LSB 0
`define CSM_SEL_X1 3'h2
// all-module-clock-stop enable position in stop register a
`define CSM_ALL_STOP_EN_BIT 15
// implemented bits; all others read as zero
`define CSM_MASK_SEL 16'h0777
`define CSM_MASK_A 16'hB329
`define CSM_MASK_B 16'h97C0
`define CSM_MASK_C 16'hFC1F
// module gates of stop register a, enable bit excluded
`define CSM_GATES_A 16'h3329
// reset values
`define CSM_RST_SEL 16'h0222
`define CSM_RST_A 16'h0000
`define CSM_RST_B 16'h0000
`define CSM_RST_C 16'h0000
// divider counter width, enough for the slowest ratio of 32
`define CSM_DIV_W 5
`endif

// ---- core/csm_pkg.sv ----
// types of the clock-select and module-stop block
// assumes the constants header csm_cfg.svh
`include "csm_cfg.svh"
package csm_pkg;
   typedef enum logic {CSM_BUS_IDLE, CSM_BUS_ANSWER} csm_bus_e;
   typedef enum logic {CSM_PWR_RUN, CSM_PWR_ALL_STOP} csm_pwr_e;
   typedef struct packed {
      logic [15:0] clk_sel;
      logic [15:0] stop_a;
      logic [15:0] stop_b;
      logic [15:0] stop_c;
      logic [2:0][`CSM_DIV_W-1:0] div_cnt;
      logic [2:0] tick;
      csm_bus_e bus;
      logic waitreq;
      logic [31:0] rdata;
      csm_pwr_e pwr;
      logic all_stop;
   } csm_state_s;
endpackage

// ---- core/csm_top.sv ----
// clock-select and module-stop control with an Avalon-MM slave
// assumes one 25 MHz clock, a synchronous active-high reset and a
// master that holds each request until it sees waitrequest low
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "csm_cfg.svh"

// How it works
// - system clock ticks from the input clock; selector 010 means x1
// - peripheral clock ticks from its selector; 010 means x1
// - external bus clock ticks from its selector; 010 means x1
// - a one in a stop bit stops that module; zero runs it
// - enable bit plus all stopped plus sleep halts bus and ports
// - stop register a: bit 13 dma, bit 12 transfer controller
// - stop register a: bit 9 timers 3 and 2, bit 8 timers 1 and 0
// - stop register a: bit 5 dac, bit 3 adc 0, bit 0 pulse timer
// - stop register b: pulse gen, serial 4/2/1/0, two-wire 1 and 0
// - stop register c: bit 15 serial 5, bit 14 serial 6
// - stop register c: timers 4/5, timers 6/7, usb, crc
// - stop register c: bits 4 to 0 gate ram banks, bit 0 highest
module csm_top
   import csm_pkg::*;
(
   input wire logic clk, // 25 MHz input clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic [23:0] avs_address, // word index of the register
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data, low half used
   input wire logic [3:0] avs_byteenable, // byte lanes of the write
   output logic [31:0] avs_readdata, // read data, upper half zero
   output logic avs_waitrequest, // low for the answering cycle
   input wire logic sleep_req, // cpu executes sleep, one cycle
   input wire logic wake_req, // wake event ends all-module stop
   output logic sys_tick, // system clock enable tick
   output logic periph_tick, // peripheral clock enable tick
   output logic bus_tick, // external bus clock enable tick
   output logic [15:0] module_stop_a, // stop register a contents
   output logic [15:0] module_stop_b, // stop register b contents
   output logic [15:0] module_stop_c, // stop register c contents
   output logic all_clock_stop // bus controller and ports halted
);

   csm_state_s state_reg;
   csm_state_s state_next;
   logic [2:0] hit;
   logic [2:0][`CSM_DIV_W-1:0] cnt_step;
   logic run;
   logic all_gated;
   logic [15:0] read_value;

   // last count of a divider: 010 and below run at x1,
   // each step above halves the rate
   function automatic logic [`CSM_DIV_W-1:0] last_count(input logic [2:0] sel);
      logic [`CSM_DIV_W-1:0] v;
      v = '0;
      case (sel)
         3'h3: v = 5'h01;
         3'h4: v = 5'h03;
         3'h5: v = 5'h07;
         3'h6: v = 5'h0F;
         3'h7: v = 5'h1F;
         default: v = 5'h00;
      endcase
      return v;
   endfunction

   // byte-lane merge of a write, keeping unimplemented bits at zero
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [31:0] data,
      input logic [3:0] be,
      input logic [15:0] mask
   );
      logic [15:0] v;
      v = old;
      if (be[0])
      begin
         v[7:0] = data[7:0];
      end
      if (be[1])
      begin
         v[15:8] = data[15:8];
      end
      return v & mask;
   endfunction

   // ticks stop while every module clock is halted
   assign run = (state_reg.pwr == CSM_PWR_RUN);

   // one divider per clock domain: 0 system, 1 peripheral, 2 bus
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_div
         localparam int LSB = (g == 0) ? `CSM_SYS_SEL_LSB :
                              (g == 1) ? `CSM_PER_SEL_LSB : `CSM_BUS_SEL_LSB;
         // selector sets the rate
         // the same divider serves and
         assign hit[g] = state_reg.div_cnt[g] >=
                         last_count(state_reg.clk_sel[LSB+2:LSB]);
         assign cnt_step[g] = hit[g] ? '0 :
                              state_reg.div_cnt[g] + `CSM_DIV_W'(1);
      end
   endgenerate

   // every gated module stopped and the enable bit set
   // entry condition
   assign all_gated = state_reg.stop_a[`CSM_ALL_STOP_EN_BIT] &&
                      ((state_reg.stop_a & `CSM_GATES_A) == `CSM_GATES_A) &&
                      (state_reg.stop_b == `CSM_MASK_B) &&
                      (state_reg.stop_c == `CSM_MASK_C);

   // read mux; unmapped indices answer zero
   // read back
   always_comb
   begin
      case (avs_address)
         `CSM_IDX_CLK_SEL: read_value = state_reg.clk_sel;
         `CSM_IDX_STOP_A: read_value = state_reg.stop_a;
         `CSM_IDX_STOP_B: read_value = state_reg.stop_b;
         `CSM_IDX_STOP_C: read_value = state_reg.stop_c;
         default: read_value = 16'h0000;
      endcase
   end

   // next state of the whole block
   always_comb
   begin
      state_next = state_reg;
      state_next.tick = 3'h0;
      // dividers hold their count in all-module stop so the phase survives
      if (run)
      begin
         state_next.div_cnt = cnt_step;
         state_next.tick = hit;
      end
      // bus handshake: one wait cycle, then one answering cycle
      case (state_reg.bus)
         CSM_BUS_IDLE:
         begin
            state_next.waitreq = 1'b1;
            if (avs_read || avs_write)
            begin
               state_next.bus = CSM_BUS_ANSWER;
               state_next.waitreq = 1'b0;
               state_next.rdata = {16'h0000, read_value};
            end
         end
         CSM_BUS_ANSWER:
         begin
            state_next.bus = CSM_BUS_IDLE;
            state_next.waitreq = 1'b1;
            // the write lands on the edge that sees waitrequest low
            if (avs_write)
            begin
               case (avs_address)
                  `CSM_IDX_CLK_SEL:
                  begin
                     state_next.clk_sel = merge(state_reg.clk_sel, avs_writedata,
                                                avs_byteenable, `CSM_MASK_SEL);
                  end
                  `CSM_IDX_STOP_A:
                  begin
                     // stop bits of register a
                     // the mask places
                     state_next.stop_a = merge(state_reg.stop_a, avs_writedata,
                                               avs_byteenable, `CSM_MASK_A);
                  end
                  `CSM_IDX_STOP_B:
                  begin
                     state_next.stop_b = merge(state_reg.stop_b, avs_writedata,
                                               avs_byteenable, `CSM_MASK_B);
                  end
                  `CSM_IDX_STOP_C:
                  begin
                     state_next.stop_c = merge(state_reg.stop_c, avs_writedata,
                                               avs_byteenable, `CSM_MASK_C);
                  end
                  default:
                  begin
                     state_next.stop_c = state_reg.stop_c;
                  end
               endcase
            end
         end
         default:
         begin
            state_next.bus = CSM_BUS_IDLE;
            state_next.waitreq = 1'b1;
         end
      endcase
      // all-module clock stop is entered only from sleep
      // enter and leave
      case (state_reg.pwr)
         CSM_PWR_RUN:
         begin
            if (sleep_req && all_gated)
            begin
               state_next.pwr = CSM_PWR_ALL_STOP;
            end
         end
         CSM_PWR_ALL_STOP:
         begin
            if (wake_req)
            begin
               state_next.pwr = CSM_PWR_RUN;
            end
         end
         default:
         begin
            state_next.pwr = CSM_PWR_RUN;
         end
      endcase
      state_next.all_stop = (state_next.pwr == CSM_PWR_ALL_STOP);
   end

   // single state register; gating never clears module state
   // state kept
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_reg.clk_sel <= `CSM_RST_SEL;
         state_reg.stop_a <= `CSM_RST_A;
         state_reg.stop_b <= `CSM_RST_B;
         state_reg.stop_c <= `CSM_RST_C;
         state_reg.div_cnt <= '0;
         state_reg.tick <= 3'h0;
         state_reg.bus <= CSM_BUS_IDLE;
         state_reg.waitreq <= 1'b1;
         state_reg.rdata <= 32'h00000000;
         state_reg.pwr <= CSM_PWR_RUN;
         state_reg.all_stop <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // outputs are fields of the state register
   assign avs_readdata = state_reg.rdata;
   assign avs_waitrequest = state_reg.waitreq;
   assign sys_tick = state_reg.tick[0];
   assign periph_tick = state_reg.tick[1];
   assign bus_tick = state_reg.tick[2];
   assign module_stop_a = state_reg.stop_a;
   assign module_stop_b = state_reg.stop_b;
   assign module_stop_c = state_reg.stop_c;
   assign all_clock_stop = state_reg.all_stop;

   // checks on the design's own outputs
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_req_seen;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   sequence s_answered;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   sequence s_write_a;
      avs_write && !avs_waitrequest && (avs_address == `CSM_IDX_STOP_A) &&
      (avs_byteenable[1:0] == 2'h3);
   endsequence

   // a request gets exactly one answer cycle after one wait cycle
   // answer timing
   a_bus_answer_cycle: assert property (s_req_seen |=> s_answered)
      else $error("bus answer not one cycle after request");

   // read of clock select returns the stored selectors
   // read back
   a_sel_read_back: assert property (
      avs_read && avs_waitrequest && (avs_address == `CSM_IDX_CLK_SEL)
      |=> avs_readdata == {16'h0000, $past(state_reg.clk_sel)})
      else $error("clock select read back wrong");

   // selector 010 gives a tick on every cycle
   // x1 rate
   a_sys_tick_x1: assert property (
      (state_reg.clk_sel[10:8] == `CSM_SEL_X1) && run |=> sys_tick)
      else $error("system tick missing at x1");

   a_periph_tick_x1: assert property (
      (state_reg.clk_sel[6:4] == `CSM_SEL_X1) && run |=> periph_tick)
      else $error("peripheral tick missing at x1");

   a_bus_tick_x1: assert property (
      (state_reg.clk_sel[2:0] == `CSM_SEL_X1) && run |=> bus_tick)
      else $error("bus tick missing at x1");

   // a full write to stop register a stores the implemented bits
   // stop write
   a_stop_a_write: assert property (s_write_a |=>
      module_stop_a == ($past(avs_writedata[15:0]) & `CSM_MASK_A))
      else $error("stop register a write not stored");

   // unimplemented bits of the stop registers stay zero
   // bit map
   a_stop_map_zero: assert property (
      ((module_stop_a & ~`CSM_MASK_A) == 16'h0000) &&
      ((module_stop_b & ~`CSM_MASK_B) == 16'h0000) &&
      ((module_stop_c & ~`CSM_MASK_C) == 16'h0000))
      else $error("unimplemented stop bit set");

   // sleep with everything gated enters the all-module stop
   // entry
   a_all_stop_entry: assert property (
      sleep_req && all_gated && !all_clock_stop |=> all_clock_stop ##1 !bus_tick)
      else $error("all-module stop not entered");

   // without the enable bit the stop never starts
   // disabled
   a_all_stop_off: assert property (
      !module_stop_a[`CSM_ALL_STOP_EN_BIT] && !all_clock_stop |=> !all_clock_stop)
      else $error("all-module stop entered while disabled");

   // a wake event ends the all-module stop on the next edge
   // leave
   a_all_stop_exit: assert property (
      all_clock_stop && wake_req |=> !all_clock_stop)
      else $error("all-module stop not left on wake");

   // registers change only on the answering edge of a write
   // state kept
   a_regs_hold: assert property (
      !(avs_write && !avs_waitrequest) |=> $stable(module_stop_a) &&
      $stable(module_stop_b) && $stable(module_stop_c) && $stable(state_reg.clk_sel))
      else $error("register changed without a write");

endmodule
`default_nettype wire

// ---- sim/tb_clock_select_module_stop.sv ----
// self-checking bench for the clock-select and module-stop block
// assumes the design files under core/, one 25 MHz clock and csm_cfg.svh
`timescale 1ns/1ps
`default_nettype none
`include "csm_cfg.svh"

`define TB_CHK(nm, e, g) \
   begin \
      total_checks++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("[ERR] %s expected %h seen %h", nm, e, g); \
      end \
   end

module tb_clock_select_module_stop;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [23:0] avs_address = 24'h000000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic sleep_req = 1'b0;
   logic wake_req = 1'b0;
   logic sys_tick;
   logic periph_tick;
   logic bus_tick;
   logic [15:0] module_stop_a;
   logic [15:0] module_stop_b;
   logic [15:0] module_stop_c;
   logic all_clock_stop;
   int fails = 0;
   int total_checks = 0;
   logic [31:0] rng = 32'h0000E024;
   logic [15:0] shadow [4];
   logic [23:0] idx_tab [4] = '{`CSM_IDX_CLK_SEL, `CSM_IDX_STOP_A, `CSM_IDX_STOP_B,
                                `CSM_IDX_STOP_C};

   // 40 ns period
   always #20 clk = ~clk;

   csm_top dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sleep_req(sleep_req), .wake_req(wake_req),
      .sys_tick(sys_tick), .periph_tick(periph_tick), .bus_tick(bus_tick),
      .module_stop_a(module_stop_a), .module_stop_b(module_stop_b),
      .module_stop_c(module_stop_c), .all_clock_stop(all_clock_stop));

   // xorshift source; fixed start keeps runs repeatable
   function automatic logic [31:0] next_rand();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // implemented bits, one mask per register from its gate bit list
   function automatic logic [15:0] reg_mask(input int i);
      case (i)
         0: return 16'h0777;
         1: return 16'hB329;
         2: return 16'h97C0;
         default: return 16'hFC1F;
      endcase
   endfunction

   // byte lanes update independently, then unimplemented bits drop out
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                         input logic [3:0] be, input logic [15:0] m);
      logic [15:0] n;
      n = old;
      if (be[0])
      begin
         n[7:0] = d[7:0];
      end
      if (be[1])
      begin
         n[15:8] = d[15:8];
      end
      return n & m;
   endfunction

   // ticks expected in n cycles; codes at or below x1 tick every cycle
   function automatic int exp_ticks(input logic [2:0] s, input int n);
      return (s <= 3'h2) ? n : (n >> (s - 3'h2));
   endfunction

   function automatic logic [15:0] port_of(input int i);
      return (i == 1) ? module_stop_a : ((i == 2) ? module_stop_b : module_stop_c);
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // one Avalon transfer; request held until waitrequest is seen low
   task automatic bus_xfer(input logic wr, input logic [23:0] a, input logic [15:0] d,
                           input logic [3:0] be, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= {rng[31:16], d};
      avs_byteenable <= be;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0)
      begin
         fails++;
         // a stuck bus is counted; the run still ends at the verdict
         $display("[ERR] waitrequest expected 0 seen %b", avs_waitrequest);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr_reg(input int i, input logic [15:0] d, input logic [3:0] be);
      logic [31:0] rd;
      bus_xfer(1'b1, idx_tab[i], d, be, rd);
      shadow[i] = merge(shadow[i], d, be, reg_mask(i));
   endtask

   task automatic check_reg(input int i);
      logic [31:0] rd;
      bus_xfer(1'b0, idx_tab[i], 16'h0000, 4'hF, rd);
      `TB_CHK("readback", {16'h0000, shadow[i]}, rd)
      if (i > 0)
         `TB_CHK("stop port", shadow[i], port_of(i))
   endtask

   task automatic count_ticks(input int n, output int cs, output int cp, output int cb);
      cs = 0;
      cp = 0;
      cb = 0;
      repeat (n)
      begin
         @(posedge clk);
         cs += (sys_tick === 1'b1);
         cp += (periph_tick === 1'b1);
         cb += (bus_tick === 1'b1);
      end
   endtask

   task automatic sleep_try(input logic exp);
      @(posedge clk);
      sleep_req <= 1'b1;
      @(posedge clk);
      sleep_req <= 1'b0;
      @(posedge clk);
      `TB_CHK("all stop", exp, all_clock_stop)
   endtask

   initial
   begin : main_seq
      int i;
      int cs;
      int cp;
      int cb;
      logic [2:0] s;
      logic [31:0] rd;
      logic [31:0] r;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      shadow = '{16'h0222, 16'h0000, 16'h0000, 16'h0000};
      for (i = 0; i < 4; i++)
         check_reg(i);
      $display("test reset values done");
      // every implemented gate bit sets, the rest stay zero
      for (i = 0; i < 4; i++)
      begin
         wr_reg(i, 16'hFFFF, 4'h3);
         check_reg(i);
         wr_reg(i, 16'h0000, 4'h3);
         check_reg(i);
      end
      // random lanes and data; bits 3:2 of byteenable are don't-care
      repeat (40)
      begin
         i = next_rand() % 4;
         r = next_rand();
         wr_reg(i, r[15:0], r[19:16]);
         check_reg(i);
      end
      $display("test bit map and readback done");
      // unmapped index reads zero and writes nothing
      bus_xfer(1'b1, 24'hFFFDC6, 16'hFFFF, 4'hF, rd);
      bus_xfer(1'b0, 24'hFFFDC6, 16'h0000, 4'hF, rd);
      `TB_CHK("unmapped read", 32'h00000000, rd)
      for (i = 0; i < 4; i++)
         check_reg(i);
      $display("test unmapped done");
      // every selector code on each of the three fields
      for (i = 0; i < 8; i++)
      begin
         s = i[2:0];
         wr_reg(0, {5'h00, s, 1'b0, s + 3'h1, 1'b0, s + 3'h2}, 4'h3);
         // divider phase after a change is unknown; one slowest period lets it settle
         repeat (32) @(posedge clk);
         count_ticks(64, cs, cp, cb);
         `TB_CHK("sys ticks", exp_ticks(s, 64), cs)
         `TB_CHK("periph ticks", exp_ticks(s + 3'h1, 64), cp)
         `TB_CHK("bus ticks", exp_ticks(s + 3'h2, 64), cb)
      end
      $display("test clock select done");
      // sleep is refused without enable or with one gate open
      wr_reg(0, 16'h0222, 4'h3);
      wr_reg(2, 16'hFFFF, 4'h3);
      wr_reg(3, 16'hFFFF, 4'h3);
      wr_reg(1, 16'h7FFF, 4'h3);
      sleep_try(1'b0);
      wr_reg(1, 16'hFFFF, 4'h3);
      wr_reg(3, 16'hFFFE, 4'h1);
      sleep_try(1'b0);
      wr_reg(3, 16'hFFFF, 4'h1);
      sleep_try(1'b1);
      count_ticks(16, cs, cp, cb);
      `TB_CHK("halted ticks", 0, cs + cp + cb)
      check_reg(1);
      @(posedge clk);
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      @(posedge clk);
      `TB_CHK("woken", 1'b0, all_clock_stop)
      count_ticks(16, cs, cp, cb);
      `TB_CHK("resumed ticks", 48, cs + cp + cb)
      $display("test all-module stop done");
      // a reset in mid-run brings every register back to its reset value
      wr_reg(0, 16'h0555, 4'h3);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      shadow = '{16'h0222, 16'h0000, 16'h0000, 16'h0000};
      `TB_CHK("stop a after reset", 16'h0000, module_stop_a)
      `TB_CHK("wait after reset", 1'b1, avs_waitrequest)
      for (i = 0; i < 4; i++)
         check_reg(i);
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
